// ---- verilog/spf_pkg.sv ----
package spf_pkg;
    // APB byte addresses of the port registers
    localparam logic [7:0] ADDR_PIN_LEVEL     = 8'h00;
    localparam logic [7:0] ADDR_OUTPUT_LATCH  = 8'h04;
    localparam logic [7:0] ADDR_DIRECTION     = 8'h08;
    // Shared addresses: analog selects overlay these defaults
    localparam logic [7:0] ADDR_SHARED_LOW    = 8'h0C;
    localparam logic [7:0] ADDR_SHARED_HIGH   = 8'h10;
    localparam logic [7:0] ADDR_WATCHDOG_CTRL = 8'h14;
    localparam logic [7:0] ADDR_PERIPH_CTRL   = 8'h18;

    localparam int        PORT_W            = 8;
    localparam logic [7:0] PORT_IMPL_MASK   = 8'hFC;
    localparam int        SHARED_ACCESS_BIT = 4;
    // Analog select bit positions for the shared pins
    localparam int        SEL_LOW_BIT2      = 7;
    localparam int        SEL_HIGH_BIT5     = 2;
    localparam int        SEL_HIGH_BIT6     = 3;
    localparam logic [7:0] SEL_LOW_MASK     = 8'h9F;
    localparam logic [7:0] SEL_HIGH_MASK    = 8'hFC;

    // Peripheral control register bits
    localparam int PC_TRANSCEIVER_DISABLE   = 0;
    localparam int PC_CMP_REF_OUT           = 1;
    localparam int PC_CMP_ONE_OUT_EN        = 2;
    localparam int PC_PARALLEL_ADDR5_EN     = 3;
    localparam logic [7:0] PERIPH_MASK      = 8'h0F;

    localparam logic [7:0] LATCH_RESET      = 8'h00;
    localparam logic [7:0] DIRECTION_RESET  = 8'hFC;
    localparam logic [7:0] SEL_RESET        = 8'h00;
    localparam logic [7:0] WDT_RESET        = 8'h00;
    localparam logic [7:0] PERIPH_RESET     = 8'h00;
endpackage : spf_pkg

// ---- verilog/spf_sync_if.sv ----
`timescale 1ns/10ps
interface spf_sync_if #(parameter int W = 8);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport owner (output raw, input clean);
    modport sync  (input raw, output clean);
endinterface : spf_sync_if

// ---- verilog/spf_pin_sync.sv ----
`timescale 1ns/10ps
module spf_pin_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic  MCLK,
    input  wire logic  RESETN,
    // Pins in, filtered level out
    spf_sync_if.sync   sp
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } spf_sync_t;

    spf_sync_t st_r;
    spf_sync_t st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = sp.raw;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        // Level moves only once two stages agree, filtering one-off glitches
        for (int i = 0; i < W; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.lvl[i] = st_r.s3[i];
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sp.clean = st_r.lvl;
endmodule : spf_pin_sync

// ---- verilog/spf_port.sv ----
// Summary of operation
// - Direction 0 drives latch, analog irrelevant
// - Direction 1 samples pin unless analog
// - Bits 2,5,6 reset as analog channels
// - Bits 3,4 input only or USB
// - Reference output kills bit 5 I/O
// - Placement 0 routes parallel data bits
// - Bit 2 outputs parallel address bit5
// - Bit 7 slave select, comparator output
// - Bits 1,0 read as zero
// - Analog selects reached only when shared bit set
// - After reset shared analog pins read 0
`timescale 1ns/10ps
module spf_port
    import spf_pkg::*;
#(
    parameter bit PLACEMENT_DEFAULT = 1'b1
) (
    // Clock and reset
    input  wire logic [0:0]  MCLK,
    input  wire logic [0:0]  RESETN,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Pins, bits 7..2 used
    input  wire logic [7:0]  PIN_IN,
    output logic      [7:0]  PIN_OUT,
    output logic      [7:0]  PIN_OE,
    // Device strap for parallel port placement
    input  wire logic        PARALLEL_PORT_PLACEMENT,
    // Parallel master port
    input  wire logic [2:0]  PARALLEL_DATA_OUT,
    input  wire logic        PARALLEL_DATA_OE,
    output logic      [2:0]  PARALLEL_DATA_IN,
    input  wire logic        PARALLEL_ADDRESS_BIT5,
    // USB transceiver, minus on bit 3, plus on bit 4
    input  wire logic [1:0]  USB_LINE_OUT,
    input  wire logic        USB_LINE_OE,
    output logic      [1:0]  USB_LINE_IN,
    // Other peripherals
    input  wire logic        COMPARATOR_ONE_OUTPUT,
    output logic             SERIAL_ONE_SLAVE_SELECT,
    // Analog use of shared pins, bits 6,5,2
    output logic      [7:0]  ANALOG_ENABLE,
    // Analog channels 7, 10, 11 active
    output logic      [2:0]  ANALOG_CHANNEL_ACTIVE
);
    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] dir;
        logic [7:0] sel_low;
        logic [7:0] sel_high;
        logic [7:0] wdt;
        logic [7:0] periph;
        logic       placement;
        logic       strap_done;
        logic [31:0] rdata;
    } spf_state_t;

    spf_state_t st_r;
    spf_state_t st_nxt;

    spf_sync_if #(.W(PORT_W)) sync_bus ();

    spf_pin_sync #(.W(PORT_W)) u_sync (
        .MCLK   (MCLK),
        .RESETN (RESETN),
        .sp     (sync_bus.sync)
    );
    assign sync_bus.raw = PIN_IN;

    logic [7:0] pins;
    logic [7:0] analog;
    logic [7:0] usb_own;
    logic [7:0] dig_in_ok;
    logic [7:0] port_read;
    logic       shared_on;
    logic       wr_en;
    logic       rd_en;
    logic       par_on;

    assign pins      = sync_bus.clean;
    assign shared_on = st_r.wdt[SHARED_ACCESS_BIT];
    assign par_on    = !st_r.placement;
    assign wr_en     = PSEL && PENABLE && PWRITE;
    assign rd_en     = PSEL && !PENABLE && !PWRITE;

    // Analog until the select bit is set; selects reset clear
    always_comb begin
        analog    = '0;
        analog[2] = !st_r.sel_low[SEL_LOW_BIT2];
        analog[5] = !st_r.sel_high[SEL_HIGH_BIT5];
        analog[6] = !st_r.sel_high[SEL_HIGH_BIT6];
    end

    // Transceiver owns bits 3,4 until disabled
    assign usb_own = st_r.periph[PC_TRANSCEIVER_DISABLE]
                     ? 8'h00 : 8'h18;

    always_comb begin
        dig_in_ok = st_r.dir & ~analog & ~usb_own;
        if (st_r.periph[PC_CMP_REF_OUT]) begin
            dig_in_ok[5] = 1'b0;
        end
        port_read = pins & dig_in_ok & PORT_IMPL_MASK;
    end

    // Pin drivers in priority order
    always_comb begin
        PIN_OUT = '0;
        PIN_OE  = '0;
        for (int i = 2; i < PORT_W; i++) begin
            PIN_OE[i]  = !st_r.dir[i];
            PIN_OUT[i] = st_r.latch[i];
        end
        // Bits 3,4 never drive from the latch
        PIN_OE[3]  = 1'b0;
        PIN_OE[4]  = 1'b0;
        PIN_OUT[3] = 1'b0;
        PIN_OUT[4] = 1'b0;
        if (st_r.periph[PC_PARALLEL_ADDR5_EN]) begin
            PIN_OE[2]  = 1'b1;
            PIN_OUT[2] = PARALLEL_ADDRESS_BIT5;
        end
        if (st_r.periph[PC_CMP_ONE_OUT_EN]) begin
            PIN_OE[7]  = 1'b1;
            PIN_OUT[7] = COMPARATOR_ONE_OUTPUT;
        end
        if (par_on) begin
            PIN_OE[7]  = PARALLEL_DATA_OE;
            PIN_OUT[7] = PARALLEL_DATA_OUT[0];
            PIN_OE[6]  = PARALLEL_DATA_OE;
            PIN_OUT[6] = PARALLEL_DATA_OUT[1];
            PIN_OE[5]  = PARALLEL_DATA_OE;
            PIN_OUT[5] = PARALLEL_DATA_OUT[2];
        end
        // Highest priority: reference output and transceiver
        if (st_r.periph[PC_CMP_REF_OUT]) begin
            PIN_OE[5]  = 1'b0;
            PIN_OUT[5] = 1'b0;
        end
        if (usb_own[3]) begin
            PIN_OE[3]  = USB_LINE_OE;
            PIN_OUT[3] = USB_LINE_OUT[0];
            PIN_OE[4]  = USB_LINE_OE;
            PIN_OUT[4] = USB_LINE_OUT[1];
        end
    end

    // Parallel data input bypasses the direction bits
    assign PARALLEL_DATA_IN = par_on
        ? {pins[5], pins[6], pins[7]} : 3'h0;
    assign USB_LINE_IN = usb_own[3] ? {pins[4], pins[3]} : 2'h0;
    // Slave select only through the input path of bit 7
    assign SERIAL_ONE_SLAVE_SELECT = st_r.dir[7]
        ? pins[7] : 1'b1;
    assign ANALOG_ENABLE = analog;
    assign ANALOG_CHANNEL_ACTIVE = {analog[6], analog[5], analog[2]};

    function automatic logic [31:0] spf_word(input logic [7:0] v);
        spf_word = {24'h000000, v};
    endfunction : spf_word

    always_comb begin
        st_nxt = st_r;
        // Strap caught once after reset release
        if (!st_r.strap_done) begin
            st_nxt.placement  = PARALLEL_PORT_PLACEMENT;
            st_nxt.strap_done = 1'b1;
        end
        if (wr_en) begin
            unique case (PADDR)
                ADDR_PIN_LEVEL, ADDR_OUTPUT_LATCH: begin
                    st_nxt.latch = PWDATA[7:0] & PORT_IMPL_MASK;
                end
                ADDR_DIRECTION: begin
                    st_nxt.dir = PWDATA[7:0] & PORT_IMPL_MASK;
                end
                ADDR_SHARED_LOW: begin
                    if (shared_on) begin
                        st_nxt.sel_low = PWDATA[7:0] & SEL_LOW_MASK;
                    end
                end
                ADDR_SHARED_HIGH: begin
                    if (shared_on) begin
                        st_nxt.sel_high = PWDATA[7:0] & SEL_HIGH_MASK;
                    end
                end
                ADDR_WATCHDOG_CTRL: begin
                    st_nxt.wdt = PWDATA[7:0];
                end
                ADDR_PERIPH_CTRL: begin
                    st_nxt.periph = PWDATA[7:0] & PERIPH_MASK;
                end
                default: begin
                end
            endcase
        end
        // Read data captured in setup so it is stable in access
        if (rd_en) begin
            unique case (PADDR)
                ADDR_PIN_LEVEL:     st_nxt.rdata = spf_word(port_read);
                ADDR_OUTPUT_LATCH:  st_nxt.rdata = spf_word(st_r.latch);
                ADDR_DIRECTION:     st_nxt.rdata = spf_word(st_r.dir);
                // Default registers live outside this block: read zero
                ADDR_SHARED_LOW:    st_nxt.rdata = shared_on
                    ? spf_word(st_r.sel_low) : 32'h00000000;
                ADDR_SHARED_HIGH:   st_nxt.rdata = shared_on
                    ? spf_word(st_r.sel_high) : 32'h00000000;
                ADDR_WATCHDOG_CTRL: st_nxt.rdata = spf_word(st_r.wdt);
                ADDR_PERIPH_CTRL:   st_nxt.rdata = spf_word(st_r.periph);
                default:            st_nxt.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            st_r.latch      <= LATCH_RESET;
            st_r.dir        <= DIRECTION_RESET;
            st_r.sel_low    <= SEL_RESET;
            st_r.sel_high   <= SEL_RESET;
            st_r.wdt        <= WDT_RESET;
            st_r.periph     <= PERIPH_RESET;
            st_r.placement  <= PLACEMENT_DEFAULT;
            st_r.strap_done <= 1'b0;
            st_r.rdata      <= 32'h00000000;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Zero wait states; unmapped addresses answer with an error
    assign PREADY  = 1'b1;
    assign PRDATA  = st_r.rdata;
    always_comb begin
        PSLVERR = 1'b0;
        if (PSEL && PENABLE) begin
            unique case (PADDR)
                ADDR_PIN_LEVEL, ADDR_OUTPUT_LATCH, ADDR_DIRECTION,
                ADDR_SHARED_LOW, ADDR_SHARED_HIGH,
                ADDR_WATCHDOG_CTRL, ADDR_PERIPH_CTRL: PSLVERR = 1'b0;
                default: PSLVERR = 1'b1;
            endcase
        end
    end
endmodule : spf_port

// ---- test/spf_pin_model.sv ----
`timescale 1ns/10ps
module spf_pin_model (
    // Port side
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    // Board side
    input  wire logic [7:0] ext,
    output logic      [7:0] pin_in
);
    // A driven pad reads back its own drive, an idle one the board
    assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule : spf_pin_model

// ---- test/spf_port_assertions.sv ----
`timescale 1ns/10ps
module spf_port_assertions (
    // Clock and reset
    input wire logic [0:0]  MCLK,
    input wire logic [0:0]  RESETN,
    // APB
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // Pins and status
    input wire logic [7:0]  PIN_OUT,
    input wire logic [7:0]  PIN_OE,
    input wire logic [1:0]  USB_LINE_OUT,
    input wire logic        USB_LINE_OE,
    input wire logic [7:0]  ANALOG_ENABLE,
    input wire logic [2:0]  ANALOG_CHANNEL_ACTIVE
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    logic rd_setup;
    // Read data is caught at setup, so checks look one edge later
    assign rd_setup = PSEL && !PENABLE && !PWRITE;

    a_ready_no_wait: assert property (PSEL |-> PREADY)
        else $error("ready low in transfer");
    a_err_unmapped: assert property (PSEL && PENABLE && PADDR[1:0] == 2'h0
        |-> PSLVERR == (PADDR > 8'h18)) else $error("slave error wrong");
    a_err_idle: assert property (!(PSEL && PENABLE) |-> !PSLVERR)
        else $error("slave error outside access");
    a_port_unused_zero: assert property (
        rd_setup && PADDR <= 8'h08 && PADDR[1:0] == 2'h0
        |=> PRDATA[1:0] == 2'h0 && PRDATA[31:8] == 24'h0)
        else $error("unused read bits not zero");
    a_analog_reads_zero: assert property (
        rd_setup && PADDR == 8'h00
        |=> (PRDATA[7:0] & $past(ANALOG_ENABLE)) == 8'h00)
        else $error("analog pin read not zero");
    a_reset_analog: assert property ($rose(RESETN)
        |-> ANALOG_ENABLE == 8'h64 && (PIN_OE & 8'hE4) == 8'h00)
        else $error("reset pin state wrong");
    a_channel_map: assert property (
        ANALOG_CHANNEL_ACTIVE == {ANALOG_ENABLE[6], ANALOG_ENABLE[5],
        ANALOG_ENABLE[2]} && (ANALOG_ENABLE & 8'h9B) == 8'h00)
        else $error("analog channel map wrong");
    a_usb_owner: assert property (PIN_OE[4:3] != 2'h0
        |-> PIN_OE[4:3] == 2'h3 && USB_LINE_OE
        && PIN_OUT[4:3] == USB_LINE_OUT) else $error("usb lines wrong");

    c_write: cover property (PSEL && PENABLE && PWRITE);
    c_unmapped: cover property (PSLVERR);
    c_parallel: cover property (PIN_OE[7:5] == 3'h7);
endmodule : spf_port_assertions

bind spf_port spf_port_assertions i_chk (
    .MCLK(MCLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
    .USB_LINE_OUT(USB_LINE_OUT), .USB_LINE_OE(USB_LINE_OE),
    .ANALOG_ENABLE(ANALOG_ENABLE),
    .ANALOG_CHANNEL_ACTIVE(ANALOG_CHANNEL_ACTIVE)
);

// ---- test/spf_port_tb.sv ----
`timescale 1ns/10ps
module spf_port_tb
    import spf_pkg::*;
;
    logic [0:0]  MCLK, RESETN;
    logic        PSEL, PENABLE, PWRITE, PREADY, PSLVERR, last_err;
    logic [7:0]  PADDR, PIN_IN, PIN_OUT, PIN_OE, ANALOG_ENABLE, ext;
    logic [31:0] PWDATA, PRDATA, rdat;
    logic        PARALLEL_PORT_PLACEMENT, PARALLEL_DATA_OE;
    logic        PARALLEL_ADDRESS_BIT5, COMPARATOR_ONE_OUTPUT;
    logic        USB_LINE_OE, SERIAL_ONE_SLAVE_SELECT;
    logic [2:0]  PARALLEL_DATA_OUT, PARALLEL_DATA_IN, ANALOG_CHANNEL_ACTIVE;
    logic [1:0]  USB_LINE_OUT, USB_LINE_IN;
    int          err_total, checked, cyc;

    spf_port #(.PLACEMENT_DEFAULT(1'b1)) i_dut (
        .MCLK(MCLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .PIN_IN(PIN_IN),
        .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
        .PARALLEL_PORT_PLACEMENT(PARALLEL_PORT_PLACEMENT),
        .PARALLEL_DATA_OUT(PARALLEL_DATA_OUT),
        .PARALLEL_DATA_OE(PARALLEL_DATA_OE),
        .PARALLEL_DATA_IN(PARALLEL_DATA_IN),
        .PARALLEL_ADDRESS_BIT5(PARALLEL_ADDRESS_BIT5),
        .USB_LINE_OUT(USB_LINE_OUT), .USB_LINE_OE(USB_LINE_OE),
        .USB_LINE_IN(USB_LINE_IN),
        .COMPARATOR_ONE_OUTPUT(COMPARATOR_ONE_OUTPUT),
        .SERIAL_ONE_SLAVE_SELECT(SERIAL_ONE_SLAVE_SELECT),
        .ANALOG_ENABLE(ANALOG_ENABLE),
        .ANALOG_CHANNEL_ACTIVE(ANALOG_CHANNEL_ACTIVE));
    spf_pin_model i_pins (.pin_out(PIN_OUT), .pin_oe(PIN_OE), .ext(ext),
        .pin_in(PIN_IN));

    initial begin
        MCLK = 1'b0;
        forever #50 MCLK = ~MCLK;
    end

    task automatic conclude();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude

    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_total++;
            conclude();
        end
    end

    // Off the edge, so outputs launched by the last write have landed
    task automatic chk(input string nm, input logic [31:0] exp, got);
        #1;
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask : chk

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge MCLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        @(posedge MCLK);
        while (PREADY !== 1'b1 && n < 20) begin
            @(posedge MCLK);
            n++;
        end
        if (n == 20) err_total++;
        rdat = PRDATA;
        last_err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        // Task arguments are copied on entry: let this edge's updates land
        #1;
    endtask : xfer

    task automatic rchk(input string nm, input logic [7:0] a,
                        input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(nm, exp, rdat);
    endtask : rchk

    task automatic rst();
        RESETN <= 1'b0;
        repeat (3) @(posedge MCLK);
        RESETN <= 1'b1;
        repeat (5) @(posedge MCLK);
    endtask : rst

    task automatic make_digital();
        xfer(1'b1, ADDR_WATCHDOG_CTRL, 32'h10);
        xfer(1'b1, ADDR_SHARED_LOW, 32'h80);
        xfer(1'b1, ADDR_SHARED_HIGH, 32'h0C);
        xfer(1'b1, ADDR_WATCHDOG_CTRL, 32'h00);
    endtask : make_digital

    initial begin
        {RESETN, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
        {err_total, checked, cyc} = '0;
        {PARALLEL_DATA_OUT, PARALLEL_DATA_OE, PARALLEL_ADDRESS_BIT5} = '0;
        {COMPARATOR_ONE_OUTPUT, last_err} = '0;
        PARALLEL_PORT_PLACEMENT = 1'b1;
        USB_LINE_OUT = 2'h2;
        USB_LINE_OE = 1'b1;
        ext = 8'hFF;
        rst();
        chk("usb in", 32'h2, 32'(USB_LINE_IN));
        rchk("dir", ADDR_DIRECTION, 32'hFC);
        rchk("level", ADDR_PIN_LEVEL, 32'h80);
        rchk("sel", ADDR_SHARED_LOW, 32'h00);
        xfer(1'b1, ADDR_PIN_LEVEL, 32'hA5);
        rchk("latch", ADDR_OUTPUT_LATCH, 32'hA4);
        xfer(1'b1, ADDR_DIRECTION, 32'h00);
        chk("oe", 32'hFC, 32'(PIN_OE));
        chk("out", 32'hB4, 32'(PIN_OUT & 8'hFC));
        chk("analog", 32'h64, 32'(ANALOG_ENABLE));
        chk("chan", 32'h7, 32'(ANALOG_CHANNEL_ACTIVE));
        xfer(1'b1, ADDR_DIRECTION, 32'hFC);
        make_digital();
        rchk("level", ADDR_PIN_LEVEL, 32'hE4);
        rchk("sel", ADDR_SHARED_LOW, 32'h00);
        xfer(1'b1, ADDR_WATCHDOG_CTRL, 32'h10);
        rchk("sel lo", ADDR_SHARED_LOW, 32'h80);
        rchk("sel hi", ADDR_SHARED_HIGH, 32'h0C);
        chk("analog", 32'h0, 32'(ANALOG_ENABLE));
        xfer(1'b1, ADDR_PERIPH_CTRL, 32'h01);
        repeat (5) @(posedge MCLK);
        rchk("level", ADDR_PIN_LEVEL, 32'hFC);
        // Reference output also blocks the input path of bit 5
        xfer(1'b1, ADDR_PERIPH_CTRL, 32'h03);
        rchk("level ref", ADDR_PIN_LEVEL, 32'hDC);
        xfer(1'b1, ADDR_PERIPH_CTRL, 32'h01);
        rchk("unmapped", 8'h1C, 32'h0);
        chk("slverr", 32'h1, 32'(last_err));
        xfer(1'b1, ADDR_DIRECTION, 32'h00);
        chk("oe", 32'hE4, 32'(PIN_OE));
        xfer(1'b1, ADDR_PERIPH_CTRL, 32'h03);
        chk("oe", 32'hC4, 32'(PIN_OE));
        xfer(1'b1, ADDR_PERIPH_CTRL, 32'h09);
        xfer(1'b1, ADDR_DIRECTION, 32'h04);
        chk("addr5", 32'h2, 32'({PIN_OE[2], PIN_OUT[2]}));
        xfer(1'b1, ADDR_PERIPH_CTRL, 32'h05);
        xfer(1'b1, ADDR_DIRECTION, 32'h84);
        chk("cmp", 32'h2, 32'({PIN_OE[7], PIN_OUT[7]}));
        @(posedge MCLK);
        ext <= 8'h7F;
        xfer(1'b1, ADDR_PERIPH_CTRL, 32'h01);
        repeat (5) @(posedge MCLK);
        chk("sel in", 32'h0, 32'(SERIAL_ONE_SLAVE_SELECT));
        xfer(1'b1, ADDR_DIRECTION, 32'h04);
        chk("sel in", 32'h1, 32'(SERIAL_ONE_SLAVE_SELECT));
        @(posedge MCLK);
        PARALLEL_PORT_PLACEMENT <= 1'b0;
        PARALLEL_DATA_OE <= 1'b1;
        PARALLEL_DATA_OUT <= 3'h3;
        rst();
        xfer(1'b1, ADDR_PERIPH_CTRL, 32'h04);
        chk("pd oe", 32'hE0, 32'(PIN_OE & 8'hE0));
        chk("pd out", 32'hC0, 32'(PIN_OUT & 8'hE0));
        @(posedge MCLK);
        PARALLEL_DATA_OE <= 1'b0;
        ext <= 8'hA0;
        xfer(1'b1, ADDR_PERIPH_CTRL, 32'h00);
        make_digital();
        chk("pd in", 32'h5, 32'(PARALLEL_DATA_IN));
        conclude();
    end
endmodule : spf_port_tb
